// ===== hw/pmc_top.sv
// PHY management registers, mode and power control, and reset sequencing
//
// Overview of operation
// [RULE1] A five-bit PHY register index is held; bits above it read zero.
// [RULE2] Sixteen-bit write data is held, low byte at the lower address.
// [RULE3] Fetched PHY data is read-only, low byte first, zero after reset.
// [RULE4] Trigger value one writes the indexed PHY register, value two reads it.
// [RULE5] The trigger clears itself at frame end; software waits for zero.
// [RULE6] Management clock divides by 32, 64 or 128 by setting; reset selects 64.
// [RULE7] Software keeps the management clock within its maximum rate.
// [RULE8] Status shows cable unplugged, link up, low speed and half duplex.
// [RULE9] Status mirrors the configured three-bit operating mode in bits five to three.
// [RULE10] Mode field picks auto-negotiation or a forced speed and duplex when unlocked.
// [RULE11] Power-down, 10BASE-Te and PHY reset accept writes only when unlocked.
// [RULE12] Software always writes one into bit six; the register resets to 0x40.
// [RULE13] Without power-down the system clock follows the clock-select input; the code also forces 25 MHz while the PHY reset bit is set.
// [RULE14] Power-down puts the PHY down and forces the 25 MHz system clock.
// [RULE15] 10BASE-Te enable acts only in auto-negotiation mode zero.
// [RULE16] Writing the reset bit starts a PHY reset at the 25 MHz clock.
// [RULE17] Reset completion clears the bit and restores the earlier clock choice.
// [RULE18] Each access runs as one clause-22 frame to the integrated PHY.
`timescale 1ns/1ns
module pmc_top #(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  input  wire logic              system_clock,
  input  wire logic              srst,
  input  wire logic [15:0]       reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_wdata,
  output logic [7:0]             reg_rdata,
  input  wire logic              phy_lock_flag,
  input  wire logic              clock_select,
  input  wire pmc_pkg::pmc_link_t link,
  input  wire logic              phy_reset_done,
  input  wire logic              mdio_i,
  output logic                   mdc,
  output logic                   mdio_o,
  output logic                   mdio_oe,
  output logic [2:0]             phy_mode,
  output logic                   phy_power_down,
  output logic                   ten_te_active,
  output logic                   phy_hw_reset,
  output logic                   system_clock_is_25m
);
  import pmc_pkg::*;

  logic [4:0]  index_q, index_d;
  logic [15:0] wdata_q, wdata_d;
  logic [15:0] rdata_q, rdata_d;
  logic [7:0]  trig_q, trig_d;
  logic [7:0]  div_q, div_d;
  logic [2:0]  mode_q, mode_d;
  logic        one_q, one_d;
  logic        power_down_bit_q, power_down_bit_d;
  logic        te_q, te_d;
  logic        rst_q, rst_d;
  logic [7:0]  bus_q, bus_d;

  logic        start;
  logic        unlocked;
  logic        eng_busy;
  logic        eng_done;
  logic [15:0] eng_rdata;
  pmc_req_t    req;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
    return a == off;
  endfunction

  function automatic logic [7:0] status_byte(input pmc_link_t l, input logic [2:0] m);
    // Speed and duplex mean nothing while the link is down, so they read zero then
    return {l.cable_unplugged, 1'b0, m, l.half_duplex & l.link_up, l.low_speed & l.link_up, l.link_up};
  endfunction

  assign unlocked = !phy_lock_flag;

  // Register writes, trigger sequencing and PHY reset handshake
  always_comb begin
    index_d = index_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    trig_d  = trig_q;
    div_d   = div_q;
    mode_d  = mode_q;
    one_d   = one_q;
    power_down_bit_d  = power_down_bit_q;
    te_d    = te_q;
    rst_d   = rst_q;
    start   = 1'b0;

    if (reg_wr && hit(reg_addr, OFF_INDEX)) begin
      index_d = reg_wdata[4:0]; // RULE1
    end
    for (int b = 0; b < 2; b++) begin
      if (reg_wr && hit(reg_addr, OFF_WDATA_LO + 16'(b))) begin
        wdata_d[8*b +: 8] = reg_wdata; // RULE2
      end
    end
    if (reg_wr && hit(reg_addr, OFF_DIVIDER)) begin
      div_d = reg_wdata; // RULE6
    end

    // A new access is refused while one is still in flight
    if (reg_wr && hit(reg_addr, OFF_TRIGGER) && trig_q == RST_TRIGGER && !eng_busy
        && (reg_wdata == ACC_WRITE || reg_wdata == ACC_READ)) begin
      start  = 1'b1; // RULE4
      trig_d = reg_wdata;
    end
    if (eng_done) begin
      trig_d = RST_TRIGGER; // RULE5
      if (trig_q == ACC_READ) begin
        rdata_d = eng_rdata; // RULE3
      end
    end

    if (reg_wr && hit(reg_addr, OFF_MODE) && unlocked) begin
      mode_d = reg_wdata[2:0]; // RULE10
    end

    // Completion clears the reset bit, but a fresh request in the same cycle wins
    if (phy_reset_done) begin
      rst_d = 1'b0; // RULE17
    end
    if (reg_wr && hit(reg_addr, OFF_POWER) && unlocked) begin
      one_d  = reg_wdata[PWR_BIT_ONE];
      power_down_bit_d = reg_wdata[PWR_BIT_POWER_DOWN_BIT]; // RULE11
      te_d   = reg_wdata[PWR_BIT_TE];
      if (reg_wdata[PWR_BIT_RST]) begin
        rst_d = 1'b1; // RULE16
      end
    end
  end

  // Read data is captured one cycle after the read strobe
  always_comb begin
    bus_d = bus_q;
    if (reg_rd) begin
      if (hit(reg_addr, OFF_STATUS)) begin
        bus_d = status_byte(link, mode_q); // RULE8 RULE9
      end else if (hit(reg_addr, OFF_INDEX)) begin
        bus_d = {3'h0, index_q}; // RULE1
      end else if (hit(reg_addr, OFF_WDATA_LO)) begin
        bus_d = wdata_q[7:0];
      end else if (hit(reg_addr, OFF_WDATA_HI)) begin
        bus_d = wdata_q[15:8];
      end else if (hit(reg_addr, OFF_RDATA_LO)) begin
        bus_d = rdata_q[7:0]; // RULE3
      end else if (hit(reg_addr, OFF_RDATA_HI)) begin
        bus_d = rdata_q[15:8];
      end else if (hit(reg_addr, OFF_TRIGGER)) begin
        bus_d = trig_q; // RULE5
      end else if (hit(reg_addr, OFF_DIVIDER)) begin
        bus_d = div_q;
      end else if (hit(reg_addr, OFF_POWER)) begin
        bus_d = {1'b0, one_q, power_down_bit_q, 1'b0, te_q, 2'b00, rst_q};
      end else begin
        // Write-only mode byte and unmapped addresses read zero
        bus_d = RST_BUS_DATA;
      end
    end
  end

  always_ff @(posedge system_clock) begin
    if (srst) begin
      index_q <= RST_INDEX;
      wdata_q <= RST_WDATA;
      rdata_q <= RST_RDATA;
      trig_q  <= RST_TRIGGER;
      div_q   <= RST_DIVIDER;
      mode_q  <= RST_MODE;
      one_q   <= RST_POWER[PWR_BIT_ONE];
      power_down_bit_q  <= RST_POWER[PWR_BIT_POWER_DOWN_BIT];
      te_q    <= RST_POWER[PWR_BIT_TE];
      rst_q   <= RST_POWER[PWR_BIT_RST];
      bus_q   <= RST_BUS_DATA;
    end else begin
      index_q <= index_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      trig_q  <= trig_d;
      div_q   <= div_d;
      mode_q  <= mode_d;
      one_q   <= one_d;
      power_down_bit_q  <= power_down_bit_d;
      te_q    <= te_d;
      rst_q   <= rst_d;
      bus_q   <= bus_d;
    end
  end

  // One driver for the whole request word: is_write, index, write data
  assign req = {reg_wdata == ACC_WRITE, index_q, wdata_q};

  pmc_mdio_frame #(
    .PHY_ADDR (PHY_ADDR)
  ) u_frame (
    .system_clock  (system_clock),
    .srst     (srst),
    .start    (start),
    .req      (req),
    .div_sel  (div_q),
    .mdio_i   (mdio_i),
    .mdc      (mdc),
    .mdio_o   (mdio_o),
    .mdio_oe  (mdio_oe),
    .busy     (eng_busy),
    .done     (eng_done),
    .rdata    (eng_rdata)
  );

  assign reg_rdata      = bus_q;
  assign phy_mode       = mode_q;
  assign phy_power_down = power_down_bit_q; // RULE14
  assign ten_te_active  = te_q && mode_q == MODE_AUTO; // RULE15
  assign phy_hw_reset   = rst_q;
  // Power-down and PHY reset both force the slow clock; clock select rules otherwise
  assign system_clock_is_25m = power_down_bit_q || rst_q || clock_select; // RULE13 RULE14 RULE16

  property p_index_reserved;
    @(posedge system_clock) disable iff (srst)
      reg_rd && reg_addr == OFF_INDEX |=> reg_rdata[7:5] == 3'h0 && reg_rdata[4:0] == index_q;
  endproperty
  a_index_reserved: assert property (p_index_reserved) else $error("index readback wrong"); // RULE1

  property p_wdata_high;
    @(posedge system_clock) disable iff (srst)
      reg_wr && reg_addr == OFF_WDATA_HI |=> wdata_q[15:8] == $past(reg_wdata);
  endproperty
  a_wdata_high: assert property (p_wdata_high) else $error("high write byte not held"); // RULE2

  property p_read_capture;
    @(posedge system_clock) disable iff (srst)
      eng_done && trig_q == ACC_READ |=> rdata_q == $past(eng_rdata) && trig_q == RST_TRIGGER;
  endproperty
  a_read_capture: assert property (p_read_capture) else $error("read data not captured"); // RULE3

  sequence s_access_running;
    trig_q != RST_TRIGGER ##1 eng_busy;
  endsequence

  property p_start_access;
    @(posedge system_clock) disable iff (srst)
      start |=> s_access_running;
  endproperty
  a_start_access: assert property (p_start_access) else $error("access did not start"); // RULE4

  property p_trigger_clears;
    @(posedge system_clock) disable iff (srst)
      $fell(eng_busy) |=> trig_q == RST_TRIGGER;
  endproperty
  a_trigger_clears: assert property (p_trigger_clears) else $error("trigger not cleared at frame end"); // RULE5

  property p_status_read;
    @(posedge system_clock) disable iff (srst)
      reg_rd && reg_addr == OFF_STATUS |=> reg_rdata[7] == $past(link.cable_unplugged)
        && reg_rdata[5:3] == $past(mode_q) && reg_rdata[0] == $past(link.link_up);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status byte wrong"); // RULE8 RULE9

  property p_mode_locked;
    @(posedge system_clock) disable iff (srst)
      reg_wr && reg_addr == OFF_MODE && phy_lock_flag |=> $stable(mode_q);
  endproperty
  a_mode_locked: assert property (p_mode_locked) else $error("mode changed while locked"); // RULE10

  property p_power_locked;
    @(posedge system_clock) disable iff (srst)
      reg_wr && reg_addr == OFF_POWER && phy_lock_flag |=> $stable(power_down_bit_q) && $stable(te_q);
  endproperty
  a_power_locked: assert property (p_power_locked) else $error("power control changed while locked"); // RULE11

  property p_clock_follows;
    @(posedge system_clock) disable iff (srst)
      !power_down_bit_q && !rst_q |-> system_clock_is_25m == clock_select;
  endproperty
  a_clock_follows: assert property (p_clock_follows) else $error("clock select not followed"); // RULE13

  property p_slow_clock;
    @(posedge system_clock) disable iff (srst)
      power_down_bit_q || rst_q |-> system_clock_is_25m;
  endproperty
  a_slow_clock: assert property (p_slow_clock) else $error("slow clock not forced"); // RULE14 RULE16

  property p_te_gate;
    @(posedge system_clock) disable iff (srst)
      ten_te_active |-> mode_q == MODE_AUTO && te_q;
  endproperty
  a_te_gate: assert property (p_te_gate) else $error("10BASE-Te active outside mode zero"); // RULE15

  property p_te_enable;
    @(posedge system_clock) disable iff (srst)
      reg_wr && reg_addr == OFF_POWER && unlocked && reg_wdata[PWR_BIT_TE] && mode_q == MODE_AUTO
        |=> ten_te_active;
  endproperty
  a_te_enable: assert property (p_te_enable) else $error("10BASE-Te not enabled in mode zero"); // RULE15

  property p_reset_done;
    @(posedge system_clock) disable iff (srst)
      rst_q && phy_reset_done && !(reg_wr && reg_addr == OFF_POWER) |=> !rst_q;
  endproperty
  a_reset_done: assert property (p_reset_done) else $error("reset bit not cleared on completion"); // RULE17

endmodule // pmc_top

// ===== include/pmc_pkg.sv
// Shared constants and types for the PHY management and mode control block
package pmc_pkg;

  localparam logic [15:0] OFF_STATUS   = 16'h3000;
  localparam logic [15:0] OFF_INDEX    = 16'h3008;
  localparam logic [15:0] OFF_WDATA_LO = 16'h300C;
  localparam logic [15:0] OFF_WDATA_HI = 16'h300D;
  localparam logic [15:0] OFF_RDATA_LO = 16'h3010;
  localparam logic [15:0] OFF_RDATA_HI = 16'h3011;
  localparam logic [15:0] OFF_TRIGGER  = 16'h3014;
  localparam logic [15:0] OFF_DIVIDER  = 16'h3018;
  localparam logic [15:0] OFF_MODE     = 16'h301C;
  localparam logic [15:0] OFF_POWER    = 16'h301D;

  localparam logic [4:0]  RST_INDEX    = 5'h00;
  localparam logic [15:0] RST_WDATA    = 16'h0000;
  localparam logic [15:0] RST_RDATA    = 16'h0000;
  localparam logic [7:0]  RST_TRIGGER  = 8'h00;
  localparam logic [7:0]  RST_DIVIDER  = 8'h01;
  localparam logic [2:0]  RST_MODE     = 3'h0;
  localparam logic [7:0]  RST_POWER    = 8'h40;
  localparam logic [7:0]  RST_BUS_DATA = 8'h00;

  // Bit positions in the power/reset control byte
  localparam int PWR_BIT_ONE  = 6;
  localparam int PWR_BIT_POWER_DOWN_BIT = 5;
  localparam int PWR_BIT_TE   = 3;
  localparam int PWR_BIT_RST  = 0;

  localparam logic [7:0] ACC_WRITE = 8'h01;
  localparam logic [7:0] ACC_READ  = 8'h02;

  localparam logic [7:0] DIV_32  = 8'h00;
  localparam logic [7:0] DIV_64  = 8'h01;
  // Half periods of the management clock, in system clock cycles, minus one
  localparam logic [5:0] HALF_32  = 6'h0F;
  localparam logic [5:0] HALF_64  = 6'h1F;
  localparam logic [5:0] HALF_128 = 6'h3F;

  localparam logic [2:0] MODE_AUTO = 3'h0;

  // Management frame layout, bit index counted from the first preamble bit
  localparam logic [31:0] FRM_PREAMBLE  = 32'hFFFF_FFFF;
  localparam logic [1:0]  FRM_START     = 2'h1;
  localparam logic [1:0]  FRM_OP_WRITE  = 2'h1;
  localparam logic [1:0]  FRM_OP_READ   = 2'h2;
  localparam logic [1:0]  FRM_TA_WRITE  = 2'h2;
  localparam logic [1:0]  FRM_TA_READ   = 2'h3;
  localparam logic [5:0]  FRM_LAST_BIT  = 6'h3F;
  localparam logic [5:0]  FRM_RD_DRIVE  = 6'h2E;
  localparam logic [5:0]  FRM_RD_DATA   = 6'h30;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_FRAME = 2'b10
  } pmc_state_t;

  typedef struct packed {
    logic cable_unplugged;
    logic half_duplex;
    logic low_speed;
    logic link_up;
  } pmc_link_t;

  typedef struct packed {
    logic        is_write;
    logic [4:0]  reg_index;
    logic [15:0] wdata;
  } pmc_req_t;

  function automatic logic [5:0] half_limit(input logic [7:0] div);
    if (div == DIV_32) begin
      return HALF_32;
    end else if (div == DIV_64) begin
      return HALF_64;
    end
    return HALF_128;
  endfunction

endpackage

// ===== hw/pmc_mdio_frame.sv
// Management frame engine: clock divider and one read or write frame
`timescale 1ns/1ns
module pmc_mdio_frame #(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  input  wire logic             system_clock,
  input  wire logic             srst,
  input  wire logic             start,
  input  wire pmc_pkg::pmc_req_t req,
  input  wire logic [7:0]       div_sel,
  input  wire logic             mdio_i,
  output logic                  mdc,
  output logic                  mdio_o,
  output logic                  mdio_oe,
  output logic                  busy,
  output logic                  done,
  output logic [15:0]           rdata
);
  import pmc_pkg::*;

  pmc_state_t  state_q, state_d;
  logic [5:0]  cnt_q, cnt_d;
  logic [5:0]  lim_q, lim_d;
  logic        mdc_q, mdc_d;
  logic [5:0]  idx_q, idx_d;
  logic [63:0] shift_q, shift_d;
  logic        wr_q, wr_d;
  logic [15:0] rx_q, rx_d;
  logic        done_q, done_d;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    lim_d   = lim_q;
    mdc_d   = mdc_q;
    idx_d   = idx_q;
    shift_d = shift_q;
    wr_d    = wr_q;
    rx_d    = rx_q;
    done_d  = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (start) begin
          state_d = ST_FRAME;
          cnt_d   = 6'h00;
          lim_d   = half_limit(div_sel); // RULE6
          mdc_d   = 1'b0;
          idx_d   = 6'h00;
          wr_d    = req.is_write;
          // RULE18
          shift_d = {FRM_PREAMBLE, FRM_START, req.is_write ? FRM_OP_WRITE : FRM_OP_READ, PHY_ADDR,
                     req.reg_index, req.is_write ? FRM_TA_WRITE : FRM_TA_READ,
                     req.is_write ? req.wdata : 16'hFFFF};
        end
      end
      ST_FRAME: begin
        if (cnt_q == lim_q) begin
          cnt_d = 6'h00;
          mdc_d = ~mdc_q;
          if (!mdc_q) begin
            // Rising edge: the PHY drives read data after turnaround
            if (!wr_q && idx_q >= FRM_RD_DATA) begin
              rx_d = {rx_q[14:0], mdio_i};
            end
          end else if (idx_q == FRM_LAST_BIT) begin
            state_d = ST_IDLE;
            done_d  = 1'b1;
          end else begin
            idx_d   = idx_q + 6'h01;
            shift_d = {shift_q[62:0], 1'b1};
          end
        end else begin
          cnt_d = cnt_q + 6'h01;
        end
      end
    endcase
  end

  always_ff @(posedge system_clock) begin
    if (srst) begin
      state_q <= ST_IDLE;
      cnt_q   <= 6'h00;
      lim_q   <= HALF_64;
      mdc_q   <= 1'b0;
      idx_q   <= 6'h00;
      shift_q <= 64'hFFFF_FFFF_FFFF_FFFF;
      wr_q    <= 1'b0;
      rx_q    <= 16'h0000;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      lim_q   <= lim_d;
      mdc_q   <= mdc_d;
      idx_q   <= idx_d;
      shift_q <= shift_d;
      wr_q    <= wr_d;
      rx_q    <= rx_d;
      done_q  <= done_d;
    end
  end

  assign busy    = (state_q == ST_FRAME);
  assign mdc     = mdc_q;
  assign mdio_o  = shift_q[63];
  assign mdio_oe = busy && (wr_q || idx_q < FRM_RD_DRIVE); // RULE18
  assign done    = done_q;
  assign rdata   = rx_q;

  property p_mdc_half_32;
    @(posedge system_clock) disable iff (srst)
      $rose(mdc_q) && lim_q == HALF_32 |-> ##15 mdc_q ##1 !mdc_q;
  endproperty
  a_mdc_half_32: assert property (p_mdc_half_32) else $error("mdc half period wrong at 1/32"); // RULE6

  property p_mdc_half_128;
    @(posedge system_clock) disable iff (srst)
      $rose(mdc_q) && lim_q == HALF_128 |-> ##63 mdc_q ##1 !mdc_q;
  endproperty
  a_mdc_half_128: assert property (p_mdc_half_128) else $error("mdc half period wrong at 1/128"); // RULE6

  sequence s_preamble;
    (mdio_oe && mdio_o)[*8];
  endsequence

  property p_preamble;
    @(posedge system_clock) disable iff (srst)
      start && !busy |=> s_preamble;
  endproperty
  a_preamble: assert property (p_preamble) else $error("frame does not open with driven ones"); // RULE18

  property p_frame_end;
    @(posedge system_clock) disable iff (srst)
      done_q |-> !busy && $past(idx_q) == FRM_LAST_BIT;
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("frame ended before its last bit"); // RULE18

endmodule // pmc_mdio_frame

// ===== verif/pmc_phy_model.sv
// Behavioural model of the integrated PHY management port and its register file
`timescale 1ns/1ns
module pmc_phy_model (
  input  wire logic system_clock,
  input  wire logic srst,
  input  wire logic mdc,
  input  wire logic mdio_o,
  input  wire logic mdio_oe,
  output logic      mdio_i
);
  logic [15:0] regs [32];
  logic [63:0] sh;
  logic [1:0]  last_st;
  logic [1:0]  last_op;
  logic [4:0]  last_phy;
  logic [4:0]  last_idx;
  logic        pre_ok;
  logic        drv;
  logic        bit_q;
  logic        mdc_q;
  int          cnt;
  int          hi_cnt;
  int          hi_len;

  // Released line floats to its pull-up level
  assign mdio_i = mdio_oe ? mdio_o : (drv ? bit_q : 1'b1);

  initial begin
    foreach (regs[i]) regs[i] = 16'h0000;
    regs[9] = 16'hA5C3;
    sh = '0;
    cnt = 0;
    hi_cnt = 0;
    hi_len = 0;
    drv = 1'b0;
    bit_q = 1'b1;
    mdc_q = 1'b0;
    pre_ok = 1'b0;
  end

  always @(posedge system_clock) begin
    if (srst) begin
      cnt = 0;
      drv = 1'b0;
    end else if (mdc && !mdc_q) begin
      sh = {sh[62:0], mdio_i};
      cnt = cnt + 1;
      if (cnt == 32) pre_ok = &sh[31:0];
      if (cnt == 46) begin
        last_st = sh[13:12];
        last_op = sh[11:10];
        last_phy = sh[9:5];
        last_idx = sh[4:0];
      end
      if (cnt == 64) begin
        if (last_op == 2'b01) regs[last_idx] = sh[15:0];
        cnt = 0;
        drv = 1'b0;
      end
    end else if (!mdc && mdc_q) begin
      hi_len = hi_cnt;
      // Turnaround low bit, then read data MSB first
      if (last_op == 2'b10 && cnt == 47) begin
        drv = 1'b1;
        bit_q = 1'b0;
      end else if (last_op == 2'b10 && cnt >= 48 && cnt <= 63) begin
        bit_q = regs[last_idx][63 - cnt];
      end
    end
    hi_cnt = mdc ? hi_cnt + 1 : 0;
    mdc_q = mdc;
  end
endmodule // pmc_phy_model

// ===== verif/tb_top.sv
// Register-level testbench for the PHY management and mode control block
`timescale 1ns/1ns
module tb_top;
  import pmc_pkg::*;
  logic        system_clock, srst, reg_wr, reg_rd, phy_lock_flag, clock_select, phy_reset_done;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rv;
  pmc_link_t   link;
  logic        mdio_i, mdc, mdio_o, mdio_oe, pdn, tea, hwr, clk25;
  logic [2:0]  phy_mode;
  int          n_mismatch, check_count, cyc;
  logic [15:0] offs [10] = '{OFF_STATUS, OFF_INDEX, OFF_WDATA_LO, OFF_WDATA_HI, OFF_RDATA_LO,
                             OFF_RDATA_HI, OFF_TRIGGER, OFF_DIVIDER, OFF_MODE, OFF_POWER};
  logic [7:0]  rstv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h40};
  logic [7:0]  divs [3] = '{8'h00, 8'h01, 8'h07};

  pmc_top u_dut (.system_clock(system_clock), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .phy_lock_flag(phy_lock_flag),
    .clock_select(clock_select), .link(link), .phy_reset_done(phy_reset_done), .mdio_i(mdio_i),
    .mdc(mdc), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .phy_mode(phy_mode), .phy_power_down(pdn),
    .ten_te_active(tea), .phy_hw_reset(hwr), .system_clock_is_25m(clk25));

  pmc_phy_model u_phy (.system_clock(system_clock), .srst(srst), .mdc(mdc), .mdio_o(mdio_o),
    .mdio_oe(mdio_oe), .mdio_i(mdio_i));

  initial begin
    system_clock = 1'b0;
    forever #10 system_clock = ~system_clock;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge system_clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge system_clock);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge system_clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge system_clock);
    reg_rd = 1'b0;
    @(negedge system_clock);
    d = reg_rdata;
  endtask

  task automatic chk_rd(input logic [15:0] a, input logic [7:0] exp);
    rd(a, rv);
    chk(16'(rv), 16'(exp));
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      rd(OFF_TRIGGER, rv);
      n++;
    end while (rv !== 8'h00 && n < 4000);
    chk(16'(rv), 16'h0000);
  endtask

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge system_clock) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      end_of_test;
    end
  end

  initial begin
    srst = 1'b1;
    reg_addr = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    phy_lock_flag = 1'b0;
    clock_select = 1'b1;
    phy_reset_done = 1'b0;
    link = '0;
    repeat (6) @(posedge system_clock);
    @(negedge system_clock);
    srst = 1'b0;
    for (int i = 0; i < 10; i++) begin
      chk_rd(offs[i], rstv[i]);
    end
    chk_rd(16'h3001, 8'h00);
    wr(OFF_INDEX, 8'hFF);
    chk_rd(OFF_INDEX, 8'h1F);
    wr(OFF_WDATA_LO, 8'h34);
    wr(OFF_WDATA_HI, 8'h12);
    chk_rd(OFF_WDATA_LO, 8'h34);
    chk_rd(OFF_WDATA_HI, 8'h12);
    // Write access, with a second trigger while busy that must be ignored
    wr(OFF_DIVIDER, DIV_32);
    wr(OFF_INDEX, 8'h05);
    wr(OFF_TRIGGER, ACC_WRITE);
    wr(OFF_TRIGGER, ACC_READ);
    chk_rd(OFF_TRIGGER, ACC_WRITE);
    wait_idle;
    chk(u_phy.regs[5], 16'h1234);
    chk(16'({u_phy.last_st, u_phy.last_op}), 16'h0005);
    chk(16'(u_phy.last_phy), 16'h0000);
    chk(16'(u_phy.pre_ok), 16'h0001);
    wr(OFF_TRIGGER, 8'h03);
    chk_rd(OFF_TRIGGER, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(OFF_DIVIDER, divs[i]);
      wr(OFF_INDEX, 8'h09);
      wr(OFF_RDATA_LO, 8'hFF);
      wr(OFF_TRIGGER, ACC_READ);
      wait_idle;
      chk_rd(OFF_RDATA_LO, 8'hC3);
      chk_rd(OFF_RDATA_HI, 8'hA5);
      chk(16'(u_phy.hi_len), 16'd16 << i);
      chk(16'(u_phy.last_idx), 16'h0009);
    end
    link = 4'b1110;
    chk_rd(OFF_STATUS, 8'h80);
    link = 4'b1111;
    chk_rd(OFF_STATUS, 8'h87);
    for (int m = 0; m < 8; m++) begin
      wr(OFF_MODE, 8'(m));
      chk(16'(phy_mode), 16'(m));
      chk_rd(OFF_STATUS, 8'h87 | 8'(m << 3));
    end
    phy_lock_flag = 1'b1;
    wr(OFF_MODE, 8'h00);
    wr(OFF_POWER, 8'h69);
    chk(16'(phy_mode), 16'h0007);
    chk(16'({pdn, hwr}), 16'h0000);
    phy_lock_flag = 1'b0;
    wr(OFF_MODE, 8'h00);
    clock_select = 1'b0;
    @(negedge system_clock);
    chk(16'(clk25), 16'h0000);
    clock_select = 1'b1;
    @(negedge system_clock);
    chk(16'(clk25), 16'h0001);
    clock_select = 1'b0;
    wr(OFF_POWER, 8'h68);
    chk(16'({pdn, clk25}), 16'h0003);
    chk(16'(tea), 16'h0001);
    wr(OFF_MODE, 8'h04);
    chk(16'(tea), 16'h0000);
    wr(OFF_POWER, 8'h41);
    chk(16'({hwr, clk25, pdn}), 16'h0006);
    chk_rd(OFF_POWER, 8'h41);
    @(negedge system_clock);
    phy_reset_done = 1'b1;
    @(negedge system_clock);
    phy_reset_done = 1'b0;
    chk(16'({hwr, clk25}), 16'h0000);
    chk_rd(OFF_POWER, 8'h40);
    end_of_test;
  end
endmodule // tb_top
